// File: pkg/uif_pkg.sv
// Purpose: Shared constants for the channel interrupt and FIFO control block
// Assumes: Host register index on a 4-bit address
// Notes:   Trigger tables hold levels in characters
package uif_pkg;
  localparam logic [3:0] ADDR_HOLD     = 4'h0;
  localparam logic [3:0] ADDR_IER      = 4'h1;
  localparam logic [3:0] ADDR_ISR_FCR  = 4'h2;
  localparam logic [3:0] ADDR_LSR      = 4'h5;
  localparam logic [3:0] ADDR_MSR      = 4'h6;
  localparam logic [3:0] ADDR_FEATURE  = 4'h8;
  localparam logic [3:0] ADDR_ENHANCED = 4'h9;
  localparam logic [3:0] ADDR_TX_TRIG  = 4'hA;
  localparam logic [3:0] ADDR_RX_TRIG  = 4'hB;

  localparam logic [7:0] RST_REG8  = 8'h00;
  localparam logic [7:0] RST_TRIG  = 8'h01;
  localparam logic [1:0] RST_SEL   = 2'h0;
  localparam logic [7:0] LEVEL_ONE = 8'h01;

  localparam int IER_RX    = 0;
  localparam int IER_TX    = 1;
  localparam int IER_LINE  = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_XOFF  = 5;
  localparam int IER_RTS   = 6;
  localparam int IER_CTS   = 7;
  localparam int EFR_ENH   = 4;
  localparam int EFR_ARTS  = 6;
  localparam int EFR_ACTS  = 7;
  localparam int FCR_EN    = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMA   = 3;
  localparam int FCR_TXLSB = 4;
  localparam int FCR_RXLSB = 6;
  localparam int FEAT_RS485 = 5;
  localparam int FEAT_TBLSB = 6;

  localparam int SRC_LINE = 0;
  localparam int SRC_RECEIVE_READY_INT = 1;
  localparam int SRC_TOUT = 2;
  localparam int SRC_TX = 3;
  localparam int SRC_MODEM = 4;
  localparam int SRC_SWFLOW = 5;
  localparam int SRC_PIN = 6;
  localparam int NUM_SRC = 7;

  localparam logic [5:0] CODE_LINE   = 6'h06;
  localparam logic [5:0] CODE_RECEIVE_READY_INT  = 6'h04;
  localparam logic [5:0] CODE_TOUT   = 6'h0C;
  localparam logic [5:0] CODE_TX     = 6'h02;
  localparam logic [5:0] CODE_MODEM  = 6'h00;
  localparam logic [5:0] CODE_SWFLOW = 6'h10;
  localparam logic [5:0] CODE_PIN    = 6'h20;
  localparam logic [5:0] CODE_NONE   = 6'h01;

  localparam int TOUT_CHARS      = 4;
  localparam int TOUT_EXTRA_BITS = 12;

  typedef enum logic [1:0] {
    TABLE_A = 2'b00,
    TABLE_B = 2'b01,
    TABLE_C = 2'b10,
    TABLE_D = 2'b11
  } uif_table_type;

  localparam logic [7:0] TRIG_A_RX [0:3] = '{8'h01, 8'h04, 8'h08, 8'h0E};
  localparam logic [7:0] TRIG_A_TX       = 8'h01;
  localparam logic [7:0] TRIG_B_RX [0:3] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  localparam logic [7:0] TRIG_B_TX [0:3] = '{8'h10, 8'h08, 8'h18, 8'h1E};
  localparam logic [7:0] TRIG_C_RX [0:3] = '{8'h08, 8'h10, 8'h38, 8'h3C};
  localparam logic [7:0] TRIG_C_TX [0:3] = '{8'h08, 8'h10, 8'h20, 8'h38};
endpackage

// File: design/uif_trig_table.sv
// Purpose: Trigger level lookup for both FIFO directions
// Assumes: One table serves receive and transmit
// Notes:   Purely combinational
`timescale 1ns/1ps
module uif_trig_table (
  input  wire uif_pkg::uif_table_type table_sel,
  input  wire logic [1:0]             rx_sel,
  input  wire logic [1:0]             tx_sel,
  input  wire logic [7:0]             rx_prog,
  input  wire logic [7:0]             tx_prog,
  output logic [7:0]                  rx_level,
  output logic [7:0]                  tx_level
);
  import uif_pkg::*;
  // Table D bypasses the selects entirely
  assign rx_level = (table_sel == TABLE_A) ? TRIG_A_RX[rx_sel] :
                    (table_sel == TABLE_B) ? TRIG_B_RX[rx_sel] :
                    (table_sel == TABLE_C) ? TRIG_C_RX[rx_sel] : rx_prog; // [RULE_22]
  assign tx_level = (table_sel == TABLE_A) ? TRIG_A_TX :
                    (table_sel == TABLE_B) ? TRIG_B_TX[tx_sel] :
                    (table_sel == TABLE_C) ? TRIG_C_TX[tx_sel] : tx_prog; // [RULE_22]
endmodule

// File: design/uif_isr_enc.sv
// Purpose: Priority encoder for the interrupt status code
// Assumes: Bit 0 of pend is the highest priority
// Notes:   Combinational; top is one-hot or zero
`timescale 1ns/1ps
module uif_isr_enc (
  input  wire logic [uif_pkg::NUM_SRC-1:0] pend,
  output logic [uif_pkg::NUM_SRC-1:0]      top,
  output logic [5:0]                       code
);
  import uif_pkg::*;
  assign top[0] = pend[0];
  for (genvar i = 1; i < NUM_SRC; i++)
  begin : g_top
    assign top[i] = pend[i] & ~(|pend[i-1:0]); // [RULE_03]
  end
  assign code = top[SRC_LINE]   ? CODE_LINE   :
                top[SRC_RECEIVE_READY_INT]  ? CODE_RECEIVE_READY_INT  :
                top[SRC_TOUT]   ? CODE_TOUT   :
                top[SRC_TX]     ? CODE_TX     :
                top[SRC_MODEM]  ? CODE_MODEM  :
                top[SRC_SWFLOW] ? CODE_SWFLOW :
                top[SRC_PIN]    ? CODE_PIN    : CODE_NONE; // [RULE_04]
endmodule

// File: design/uif_channel_ctrl.sv
// Purpose: Interrupt prioritisation and FIFO control for one channel
// Assumes: Host strobes are one-cycle pulses synchronous to core_clk
// Notes:   Serial path, FIFOs and status registers live outside
// Functional notes
// RULE_01: RTS pin change interrupt, enable bit six
// RULE_02: CTS pin change interrupt, enable bit seven
// RULE_03: Status read shows only highest pending source
// RULE_04: Six-bit source codes by priority
// RULE_05: Bit zero low while anything pending
// RULE_06: Line and modem status bits raise interrupts
// RULE_07: Timeout after four chars plus twelve bits
// RULE_08: Transmit ready on trigger, empty, or RS485
// RULE_09: Xoff or special character raises interrupt
// RULE_10: Auto CTS/DSR input rising raises change
// RULE_11: Auto RTS/DTR output rising raises change
// RULE_12: Line and modem reads clear their interrupts
// RULE_13: Receive ready level; timeout cleared by data read
// RULE_14: Status read or data write clears transmit
// RULE_15: Xoff/special cleared by read, Xon, next char
// RULE_16: Status bits seven:six show FIFO enable
// RULE_17: FIFO control ignored unless bit zero set
// RULE_18: FIFO reset bits pulse then self-clear
// RULE_19: DMA mode bit stored, no effect
// RULE_20: Transmit trigger below level or empty
// RULE_21: Receive trigger crossing, default one char
// RULE_22: Feature table picks trigger levels
// RULE_23: Channel bit mirrors pending interrupt globally
// RULE_24: Interrupt output follows any enabled pending
`timescale 1ns/1ps
module uif_channel_ctrl (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       host_cs,
  input  wire logic       host_rd,
  input  wire logic       host_wr,
  input  wire logic [3:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic [7:0]      host_rdata,
  input  wire logic [7:0] rx_data,
  input  wire logic [7:0] line_status,
  input  wire logic [7:0] modem_status,
  input  wire logic [7:0] rx_count,
  input  wire logic [7:0] tx_count,
  input  wire logic       rx_push,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  input  wire logic       xoff_detect,
  input  wire logic       special_detect,
  input  wire logic       xon_detect,
  input  wire logic       tx_all_empty,
  input  wire logic       rts_pin_n,
  input  wire logic       dtr_pin_n,
  input  wire logic       cts_pin_n,
  input  wire logic       dsr_pin_n,
  input  wire logic       flow_pin_sel,
  output logic            irq,
  output logic            chan_int,
  output logic            fifo_enable,
  output logic            rx_fifo_reset,
  output logic            tx_fifo_reset,
  output logic            dma_mode,
  output logic [7:0]      rx_trigger,
  output logic [7:0]      tx_trigger,
  output logic            auto_rs485
);
  import uif_pkg::*;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
    hit = (a == want);
  endfunction

  // Set beats clear so an event in the clearing cycle survives
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic [7:0]         ier_reg, efr_reg, feature_control_reg, transmit_trigger_value_reg, receive_trigger_value_reg;
  logic [1:0]         rx_sel_reg, tx_sel_reg;
  logic               line_flag, tout_flag, tx_flag, modem_flag;
  logic               xoff_flag, spec_flag, pin_flag;
  logic               line_q, modem_q, rts_q, cts_q, txe_q, below_q, tx_filled;
  logic [7:0]         tx_count_q, tout_cnt;
  logic [7:0]         rx_level, tx_level, rx_lvl_eff, tx_lvl_eff, tout_limit;
  logic [NUM_SRC-1:0] pend, top;
  logic [5:0]         code;
  logic [7:0]         rdata_next;

  wire rd_any   = host_cs & host_rd;
  wire wr_any   = host_cs & host_wr;
  wire rd_hold  = rd_any & hit(host_addr, ADDR_HOLD);
  wire rd_isr   = rd_any & hit(host_addr, ADDR_ISR_FCR);
  wire rd_lsr   = rd_any & hit(host_addr, ADDR_LSR);
  wire rd_msr   = rd_any & hit(host_addr, ADDR_MSR);
  wire wr_hold  = wr_any & hit(host_addr, ADDR_HOLD);
  wire wr_ier   = wr_any & hit(host_addr, ADDR_IER);
  wire wr_fcr   = wr_any & hit(host_addr, ADDR_ISR_FCR);
  wire wr_feat  = wr_any & hit(host_addr, ADDR_FEATURE);
  wire wr_enh   = wr_any & hit(host_addr, ADDR_ENHANCED);
  wire wr_transmit_trigger_value = wr_any & hit(host_addr, ADDR_TX_TRIG);
  wire wr_receive_trigger_value = wr_any & hit(host_addr, ADDR_RX_TRIG);
  wire enh      = efr_reg[EFR_ENH];
  wire fcr_ok   = wr_fcr & host_wdata[FCR_EN]; // [RULE_17]

  // Upper enables only move while enhanced functions are unlocked
  wire [7:0] ier_next = {enh ? host_wdata[7:5] : ier_reg[7:5], 1'b0, host_wdata[3:0]};

  uif_trig_table u_trig (
    .table_sel (uif_table_type'(feature_control_reg[FEAT_TBLSB +: 2])),
    .rx_sel    (rx_sel_reg),
    .tx_sel    (tx_sel_reg),
    .rx_prog   (receive_trigger_value_reg),
    .tx_prog   (transmit_trigger_value_reg),
    .rx_level  (rx_level),
    .tx_level  (tx_level)
  );

  // Without FIFOs the holding register behaves as a one-deep FIFO
  assign rx_lvl_eff = fifo_enable ? rx_level : LEVEL_ONE; // [RULE_21]
  assign tx_lvl_eff = fifo_enable ? tx_level : LEVEL_ONE;

  wire line_any = |line_status[4:1]; // [RULE_06]
  wire modem_any = |modem_status[3:0]; // [RULE_06]
  wire line_set = line_any & ~line_q;
  wire modem_set = modem_any & ~modem_q;

  wire rx_ready = (rx_count >= rx_lvl_eff); // [RULE_13] [RULE_21]

  // Timer restarts on any receive activity and holds once expired
  assign tout_limit = {2'b00, char_bits, 2'b00} + 8'(TOUT_EXTRA_BITS);
  wire tout_act = (rx_count != 8'h00) & ~rx_push & ~rd_hold;
  wire tout_set = tout_act & bit_tick & (tout_cnt == tout_limit - 8'h01); // [RULE_07]

  wire tx_below = (tx_count < tx_lvl_eff);
  wire below_evt = tx_below & ~below_q & tx_filled; // [RULE_20]
  wire empty_evt = (tx_count == 8'h00) & (tx_count_q != 8'h00) & ~tx_filled; // [RULE_20]
  wire txe_evt = tx_all_empty & ~txe_q;
  wire tx_evt = auto_rs485 ? txe_evt : (below_evt | empty_evt); // [RULE_08]
  wire tx_clr = wr_hold | (rd_isr & top[SRC_TX]); // [RULE_14]

  wire sw_clr = rd_isr & top[SRC_SWFLOW]; // [RULE_15]
  wire spec_clr = sw_clr | (rx_push & ~special_detect); // [RULE_15]

  wire rts_sel = flow_pin_sel ? dtr_pin_n : rts_pin_n;
  wire cts_sel = flow_pin_sel ? dsr_pin_n : cts_pin_n;
  wire rts_rise = rts_sel & ~rts_q;
  wire cts_rise = cts_sel & ~cts_q;
  wire rts_chg = rts_sel ^ rts_q;
  wire cts_chg = cts_sel ^ cts_q;
  wire rts_evt = enh & ier_reg[IER_RTS] &
                 (efr_reg[EFR_ARTS] ? rts_rise : rts_chg); // [RULE_01] [RULE_11]
  wire cts_evt = enh & ier_reg[IER_CTS] &
                 (efr_reg[EFR_ACTS] ? cts_rise : cts_chg); // [RULE_02] [RULE_10]

  assign pend[SRC_LINE]   = line_flag & ier_reg[IER_LINE];
  assign pend[SRC_RECEIVE_READY_INT]  = rx_ready & ier_reg[IER_RX];
  assign pend[SRC_TOUT]   = tout_flag & ier_reg[IER_RX];
  assign pend[SRC_TX]     = tx_flag & ier_reg[IER_TX];
  assign pend[SRC_MODEM]  = modem_flag & ier_reg[IER_MODEM];
  assign pend[SRC_SWFLOW] = (xoff_flag | spec_flag) & enh & ier_reg[IER_XOFF]; // [RULE_09]
  assign pend[SRC_PIN]    = pin_flag;
  wire pend_any = |pend;

  uif_isr_enc u_enc (
    .pend (pend),
    .top  (top),
    .code (code)
  );

  // Unmapped reads return zero; the control register is write-only
  assign rdata_next =
    hit(host_addr, ADDR_HOLD)     ? rx_data :
    hit(host_addr, ADDR_IER)      ? ier_reg :
    hit(host_addr, ADDR_ISR_FCR)  ? {fifo_enable, fifo_enable, code} : // [RULE_16] [RULE_05]
    hit(host_addr, ADDR_LSR)      ? line_status :
    hit(host_addr, ADDR_MSR)      ? modem_status :
    hit(host_addr, ADDR_FEATURE)  ? feature_control_reg :
    hit(host_addr, ADDR_ENHANCED) ? efr_reg :
    hit(host_addr, ADDR_TX_TRIG)  ? tx_count :
    hit(host_addr, ADDR_RX_TRIG)  ? rx_count : RST_REG8;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ier_reg   <= RST_REG8;
      efr_reg   <= RST_REG8;
      feature_control_reg  <= RST_REG8;
      transmit_trigger_value_reg <= RST_TRIG;
      receive_trigger_value_reg <= RST_TRIG;
    end
    else
    begin
      if (wr_ier)
        ier_reg <= ier_next;
      if (wr_enh)
        efr_reg <= host_wdata;
      if (wr_feat)
        feature_control_reg <= host_wdata; // [RULE_22]
      if (wr_transmit_trigger_value)
        transmit_trigger_value_reg <= host_wdata;
      if (wr_receive_trigger_value)
        receive_trigger_value_reg <= host_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_enable   <= 1'b0;
      dma_mode      <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      rx_sel_reg    <= RST_SEL;
      tx_sel_reg    <= RST_SEL;
    end
    else
    begin
      if (wr_fcr)
        fifo_enable <= host_wdata[FCR_EN]; // [RULE_17]
      rx_fifo_reset <= fcr_ok & host_wdata[FCR_RXRST]; // [RULE_18]
      tx_fifo_reset <= fcr_ok & host_wdata[FCR_TXRST]; // [RULE_18]
      if (fcr_ok)
      begin
        dma_mode   <= host_wdata[FCR_DMA]; // [RULE_19]
        rx_sel_reg <= host_wdata[FCR_RXLSB +: 2];
        if (enh)
          tx_sel_reg <= host_wdata[FCR_TXLSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      line_q     <= 1'b0;
      modem_q    <= 1'b0;
      rts_q      <= 1'b1;
      cts_q      <= 1'b1;
      txe_q      <= 1'b1;
      below_q    <= 1'b1;
      tx_filled  <= 1'b0;
      tx_count_q <= 8'h00;
      tout_cnt   <= 8'h00;
    end
    else
    begin
      line_q     <= line_any;
      modem_q    <= modem_any;
      rts_q      <= rts_sel;
      cts_q      <= cts_sel;
      txe_q      <= tx_all_empty;
      below_q    <= tx_below;
      tx_count_q <= tx_count;
      // Remembers whether the last reload went past the level
      tx_filled  <= (tx_count > tx_lvl_eff) | (tx_filled & (tx_count != 8'h00));
      if (!tout_act)
        tout_cnt <= 8'h00;
      else if (bit_tick && tout_cnt < tout_limit)
        tout_cnt <= tout_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      line_flag  <= 1'b0;
      tout_flag  <= 1'b0;
      tx_flag    <= 1'b0;
      modem_flag <= 1'b0;
      xoff_flag  <= 1'b0;
      spec_flag  <= 1'b0;
      pin_flag   <= 1'b0;
    end
    else
    begin
      line_flag  <= sticky(line_flag, line_set, rd_lsr); // [RULE_12]
      tout_flag  <= sticky(tout_flag, tout_set, rd_hold); // [RULE_13]
      tx_flag    <= sticky(tx_flag, tx_evt, tx_clr); // [RULE_14]
      modem_flag <= sticky(modem_flag, modem_set, rd_msr); // [RULE_12]
      xoff_flag  <= sticky(xoff_flag, xoff_detect, sw_clr | xon_detect); // [RULE_15]
      spec_flag  <= sticky(spec_flag, special_detect, spec_clr); // [RULE_15]
      pin_flag   <= sticky(pin_flag, rts_evt | cts_evt, rd_msr); // [RULE_12]
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_rdata <= RST_REG8;
      irq        <= 1'b0;
      chan_int   <= 1'b0;
      rx_trigger <= LEVEL_ONE;
      tx_trigger <= LEVEL_ONE;
      auto_rs485 <= 1'b0;
    end
    else
    begin
      if (rd_any)
        host_rdata <= rdata_next; // [RULE_03]
      irq        <= pend_any; // [RULE_24]
      chan_int   <= pend_any; // [RULE_23]
      rx_trigger <= rx_lvl_eff;
      tx_trigger <= tx_lvl_eff;
      auto_rs485 <= feature_control_reg[FEAT_RS485];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence rx_reset_req;
    fcr_ok && host_wdata[FCR_RXRST] ##1 !wr_fcr;
  endsequence
  sequence one_pulse;
    rx_fifo_reset ##1 !rx_fifo_reset;
  endsequence

  rts_change_a: assert property (enh && ier_reg[IER_RTS] && !efr_reg[EFR_ARTS] && rts_chg |=> pin_flag) else $error("rts change lost"); // [RULE_01]
  cts_change_a: assert property (enh && ier_reg[IER_CTS] && !efr_reg[EFR_ACTS] && cts_chg |=> pin_flag) else $error("cts change lost"); // [RULE_02]
  isr_top_a: assert property (rd_isr && pend[SRC_LINE] |=> host_rdata[5:0] == CODE_LINE) else $error("wrong top code"); // [RULE_04]
  isr_idle_a: assert property (rd_isr && !pend_any |=> host_rdata[5:0] == CODE_NONE) else $error("idle code wrong"); // [RULE_05]
  fifo_status_a: assert property (rd_isr |=> host_rdata[7:6] == {2{$past(fifo_enable)}}) else $error("fifo status wrong"); // [RULE_16]
  line_clear_a: assert property (rd_lsr && !line_set |=> !line_flag) else $error("line not cleared"); // [RULE_12]
  tout_clear_a: assert property (rd_hold && !tout_set |=> !tout_flag) else $error("timeout not cleared"); // [RULE_13]
  tx_clear_a: assert property (wr_hold && !tx_evt |=> !tx_flag) else $error("tx not cleared"); // [RULE_14]
  tout_cause_a: assert property ($rose(tout_flag) |-> $past(bit_tick) && $past(tout_cnt) == $past(tout_limit) - 8'h01) else $error("timeout early"); // [RULE_07]
  rs485_tx_a: assert property (auto_rs485 && txe_evt |=> tx_flag) else $error("rs485 tx lost"); // [RULE_08]
  fcr_ignore_a: assert property (wr_fcr && !host_wdata[FCR_EN] |=> !fifo_enable && $stable(rx_sel_reg) && $stable(dma_mode) && !rx_fifo_reset) else $error("fcr not ignored"); // [RULE_17]
  rx_reset_a: assert property (rx_reset_req |-> one_pulse) else $error("reset not one pulse"); // [RULE_18]
  irq_follow_a: assert property (1'b1 |=> irq == $past(pend_any) && chan_int == irq) else $error("irq mismatch"); // [RULE_24]
endmodule

// File: verification/uif_host_model.sv
// Purpose: Host processor model on the channel register bus
// Assumes: Tasks are entered one small delay after a rising edge
// Notes:   Address and data are scrambled while deselected
`timescale 1ns/1ps
module uif_host_model (
  input  wire logic       core_clk,
  output logic            host_cs,
  output logic            host_rd,
  output logic            host_wr,
  output logic [3:0]      host_addr,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  initial
  begin
    host_cs    = 1'b0;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_addr  = 4'hF;
    host_wdata = 8'hA5;
  end
  // Inverted leftovers so a stale address never repeats the one just driven
  task automatic bus_idle();
    host_cs    = 1'b0;
    host_rd    = 1'b0;
    host_wr    = 1'b0;
    host_addr  = ~host_addr;
    host_wdata = ~host_wdata;
  endtask
  // One idle cycle follows, so a next request never lands in the same step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    host_cs    = 1'b1;
    host_wr    = 1'b1;
    host_addr  = a;
    host_wdata = v;
    @(posedge core_clk);
    #1;
    bus_idle();
    @(posedge core_clk);
    #1;
  endtask
  // Data is taken a full cycle after the taking edge; it holds until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    host_cs   = 1'b1;
    host_rd   = 1'b1;
    host_addr = a;
    @(posedge core_clk);
    #1;
    bus_idle();
    @(posedge core_clk);
    #1;
    v = host_rdata;
  endtask
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench for channel interrupts and FIFO control
// Assumes: One channel; the host model owns the register bus
// Notes:   Flow pin select is switched to DTR/DSR only in the last test
`timescale 1ns/1ps
module tb;
  import uif_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       host_cs, host_rd, host_wr, rx_push, bit_tick, xoff_detect;
  logic       special_detect, xon_detect, tx_all_empty, rts_pin_n, dtr_pin_n;
  logic       cts_pin_n, dsr_pin_n, flow_pin_sel, irq, chan_int, fifo_enable;
  logic       rx_fifo_reset, tx_fifo_reset, dma_mode, auto_rs485;
  logic [3:0] host_addr, char_bits;
  logic [7:0] host_wdata, host_rdata, rx_data, line_status, modem_status;
  logic [7:0] rx_count, tx_count, rx_trigger, tx_trigger, d, pr, pt;
  int         err_total = 0, checks = 0, seed = 35, rxr_n = 0, txr_n = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (rx_fifo_reset === 1'b1) rxr_n++;
    if (tx_fifo_reset === 1'b1) txr_n++;
  end
  uif_host_model i_uif_host_model (.core_clk, .host_cs, .host_rd, .host_wr,
    .host_addr, .host_wdata, .host_rdata);
  uif_channel_ctrl i_uif_channel_ctrl (.core_clk, .rst, .host_cs, .host_rd,
    .host_wr, .host_addr, .host_wdata, .host_rdata, .rx_data, .line_status,
    .modem_status, .rx_count, .tx_count, .rx_push, .bit_tick, .char_bits,
    .xoff_detect, .special_detect, .xon_detect, .tx_all_empty, .rts_pin_n,
    .dtr_pin_n, .cts_pin_n, .dsr_pin_n, .flow_pin_sel, .irq, .chan_int,
    .fifo_enable, .rx_fifo_reset, .tx_fifo_reset, .dma_mode, .rx_trigger,
    .tx_trigger, .auto_rs485);
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] v);
    i_uif_host_model.wr(a, v);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string m);
    i_uif_host_model.rd(a, d);
    chk(d, e, m);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  // Expected trigger level for a table, a selection and a programmed value
  function automatic logic [7:0] lvl(input bit tx, input int t, input int s,
                                     input logic [7:0] p);
    case (t)
      0: return tx ? TRIG_A_TX : TRIG_A_RX[s];
      1: return tx ? TRIG_B_TX[s] : TRIG_B_RX[s];
      2: return tx ? TRIG_C_TX[s] : TRIG_C_RX[s];
      default: return p;
    endcase
  endfunction
  initial
  begin
    #(4 * 20000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end
  initial
  begin
    {rx_data, line_status, modem_status, rx_count, tx_count} = '0;
    {rx_push, bit_tick, xoff_detect, special_detect, xon_detect, tx_all_empty} = '0;
    {rts_pin_n, dtr_pin_n, cts_pin_n, dsr_pin_n, flow_pin_sel} = 5'b11110;
    char_bits = 4'(7 + ($random(seed) & 3));
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk({irq, chan_int, fifo_enable, dma_mode, auto_rs485, 3'b0}, 8'h00, "reset");
    chk(rx_trigger, LEVEL_ONE, "rx level reset");
    rchk(ADDR_ISR_FCR, 8'h01, "status reset");
    w(ADDR_ISR_FCR, 8'h0E);
    chk({fifo_enable, dma_mode, 2'(rxr_n), 2'(txr_n), 2'b0}, 8'h00, "fcr ignored");
    w(ADDR_ISR_FCR, 8'h0F);
    chk({fifo_enable, dma_mode, 2'(rxr_n), 2'(txr_n), 2'b0}, 8'hD4, "fcr pulses");
    rchk(ADDR_ISR_FCR, 8'hC1, "status fifo on");
    $display("test fifo control done");
    w(ADDR_ENHANCED, 8'h10);
    for (int t = 0; t < 4; t++)
      for (int s = 0; s < 4; s++)
      begin
        pr = (8'($random(seed)) & 8'h3F) | 8'h01;
        pt = (8'($random(seed)) & 8'h3F) | 8'h01;
        w(ADDR_RX_TRIG, pr);
        w(ADDR_TX_TRIG, pt);
        w(ADDR_FEATURE, {2'(t), 6'h00});
        w(ADDR_ISR_FCR, {2'(s), 2'(s), 4'h1});
        chk(rx_trigger, lvl(0, t, s, pr), "rx level");
        chk(tx_trigger, lvl(1, t, s, pt), "tx level");
      end
    w(ADDR_ISR_FCR, 8'h00);
    rchk(ADDR_ISR_FCR, 8'h01, "status fifo off");
    w(ADDR_FEATURE, 8'h00);
    w(ADDR_ISR_FCR, 8'h01);
    $display("test trigger tables done");
    w(ADDR_ENHANCED, 8'h00);
    w(ADDR_IER, 8'hFF);
    rchk(ADDR_IER, 8'h0F, "enable locked");
    w(ADDR_ENHANCED, 8'h10);
    repeat (6)
    begin
      pr = 8'($random(seed));
      w(ADDR_IER, pr);
      rchk(ADDR_IER, pr & 8'hEF, "enable readback");
    end
    rchk(4'h3, 8'h00, "unmapped");
    w(ADDR_IER, 8'hED);
    line_status = 8'h02;
    modem_status = 8'h01;
    rx_count = 8'd3;
    cts_pin_n = 1'b0;
    pulse(xoff_detect);
    step(3);
    chk({6'h0, irq, chan_int}, 8'h03, "irq up");
    rchk(ADDR_ISR_FCR, 8'hC6, "line top");
    rchk(ADDR_LSR, 8'h02, "line read");
    rchk(ADDR_ISR_FCR, 8'hC4, "rx ready top");
    rx_count = 8'd0;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hC0, "modem top");
    rchk(ADDR_MSR, 8'h01, "modem read");
    rchk(ADDR_ISR_FCR, 8'hD0, "soft flow top");
    rchk(ADDR_ISR_FCR, 8'hC1, "soft flow read");
    chk({6'h0, irq, chan_int}, 8'h00, "irq down");
    rts_pin_n = 1'b0;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hE0, "rts change");
    rchk(ADDR_MSR, 8'h01, "modem read");
    cts_pin_n = 1'b1;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hE0, "cts change");
    rchk(ADDR_MSR, 8'h01, "modem read");
    rchk(ADDR_ISR_FCR, 8'hC1, "pin cleared");
    pulse(xoff_detect);
    pulse(xon_detect);
    step(2);
    chk({7'h0, irq}, 8'h00, "xon clears");
    pulse(special_detect);
    step(2);
    chk({7'h0, irq}, 8'h01, "special");
    pulse(rx_push);
    step(2);
    chk({7'h0, irq}, 8'h00, "next char clears");
    {line_status, modem_status} = '0;
    w(ADDR_IER, 8'h0C);
    for (int b = 0; b < 4; b++)
    begin
      line_status = 8'h02 << b;
      step(3);
      rchk(ADDR_ISR_FCR, 8'hC6, "line bit");
      rchk(ADDR_LSR, line_status, "line value");
      modem_status = 8'h01 << b;
      step(3);
      rchk(ADDR_ISR_FCR, 8'hC0, "modem bit");
      rchk(ADDR_MSR, modem_status, "modem value");
      {line_status, modem_status} = '0;
      step(1);
    end
    $display("test priority done");
    w(ADDR_IER, 8'h01);
    w(ADDR_ISR_FCR, 8'hC1);
    rx_data = 8'($random(seed));
    rx_count = 8'd1;
    repeat (TOUT_CHARS * int'(char_bits) + TOUT_EXTRA_BITS - 1) pulse(bit_tick);
    step(2);
    rchk(ADDR_ISR_FCR, 8'hC1, "no early timeout");
    pulse(bit_tick);
    step(2);
    rchk(ADDR_ISR_FCR, 8'hCC, "timeout");
    rchk(ADDR_HOLD, rx_data, "rx data");
    rchk(ADDR_ISR_FCR, 8'hC1, "timeout cleared");
    rx_count = 8'd0;
    $display("test timeout done");
    w(ADDR_IER, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      tx_count = 8'd5;
      step(2);
      tx_count = 8'd0;
      step(3);
      chk({7'h0, irq}, 8'h01, "tx below level");
      if (k == 0)
        rchk(ADDR_ISR_FCR, 8'hC2, "tx ready");
      else
        w(ADDR_HOLD, 8'($random(seed)));
      rchk(ADDR_ISR_FCR, 8'hC1, "tx cleared");
    end
    w(ADDR_FEATURE, 8'h20);
    chk({7'h0, auto_rs485}, 8'h01, "half duplex");
    tx_all_empty = 1'b1;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hC2, "tx all empty");
    $display("test transmit done");
    flow_pin_sel = 1'b1;
    rts_pin_n = 1'b1;
    step(2);
    w(ADDR_ENHANCED, 8'hD0);
    w(ADDR_IER, 8'hC0);
    dsr_pin_n = 1'b0;
    dtr_pin_n = 1'b0;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hC1, "auto falling ignored");
    dsr_pin_n = 1'b1;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hE0, "dsr rising");
    rchk(ADDR_MSR, 8'h00, "modem read");
    dtr_pin_n = 1'b1;
    step(3);
    rchk(ADDR_ISR_FCR, 8'hE0, "dtr rising");
    rchk(ADDR_MSR, 8'h00, "modem read");
    rchk(ADDR_ISR_FCR, 8'hC1, "auto pin cleared");
    $display("test auto flow pins done");
    conclude();
  end
endmodule
